// ===== pmc_pkg.sv
package pmc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] FLASH_READ_TIMING_ADDR = 8'hb7;
    localparam logic [7:0] FLASH_READ_TIMING_RST = 8'h00;
    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] WAKE_CONFIG_ADDR = 8'hb5;
    localparam int ONESHOT_SKIP_POS = 6;
    localparam int IDLE_SEL_POS = 0;
    localparam int HALT_SEL_POS = 1;
    localparam int SLEEP_SEL_POS = 7;
    localparam int SUSPEND_SEL_POS = 6;
    localparam int FLAG_CLEAR_POS = 5;
    localparam int WAKE_FLAG_W = 5;
    localparam logic [7:0] FLASH_READ_TIMING_MASK = 8'h40;
    localparam logic [7:0] WAKE_ENABLE_MASK = 8'h0f;

    // ----------------------------------------
    // power modes, one-hot
    // ----------------------------------------
    typedef enum logic [4:0] {
        PMC_NORMAL  = 5'b0_0001,
        PMC_IDLE    = 5'b0_0010,
        PMC_STOP    = 5'b0_0100,
        PMC_SUSPEND = 5'b0_1000,
        PMC_SLEEP   = 5'b1_0000
    } pmc_mode_t;

    // special function register write/read port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmc_sfr_t;
endpackage : pmc_pkg

// ===== pmc_top.sv
`timescale 1ns/1ps
// Contract
// - idle entered after writing instruction completes
// - idle keeps state, peripherals run
// - enabled interrupt clears idle, restarts CPU
// - resume after idle-setting instruction
// - reset ends idle, fetch from zero
// - watchdog reset ends idle
// - stop entered after writing instruction completes
// - stop halts CPU and precision oscillator
// - only reset ends stop, fetch zero
// - missing clock reset ends stop
// - bypass zero selects one-shot read time
// - bypass one selects clock read time
// - reserved timing bits read zero
// - any instruction may follow bypass clear
// - five modes with entry and wake
// - suspend gates clock, oscillators off
// - sleep gates supply, keeps rtc only
// - sleep select bit enters sleep
// - suspend select bit enters suspend
// - flag clear bit clears all flags; a wake event in the same cycle stays set
module pmc_top #(
    parameter int WAKE_W = pmc_pkg::WAKE_FLAG_W // wake flag count
) (
    input  wire logic CLK_I,                    // 200 MHz system clock
    input  wire logic SYS_RST_I,                // sync reset, high
    input  wire logic CLK_EN_I,                 // freezes state when low
    input  wire pmc_pkg::pmc_sfr_t SFR_I,       // cpu register access
    input  wire logic INSN_DONE_I,              // writing instruction retired
    input  wire logic IRQ_PEND_I,               // enabled interrupt asserted
    input  wire logic WDT_RST_I,                // watchdog timeout reset
    input  wire logic MCD_RST_I,                // missing clock reset
    input  wire logic EXT_RST_I,                // external reset
    input  wire logic [WAKE_W-1:0] WAKE_EV_I,   // suspend/sleep wake events
    output logic [7:0] SFR_RDATA_O,             // read data
    output logic CPU_HALT_O,                    // cpu halted
    output logic CPU_RESET_O,                   // reset, fetch from zero
    output logic PREC_OSC_EN_O,                 // precision oscillator on
    output logic ALL_OSC_EN_O,                  // internal oscillators on
    output logic SYSCLK_GATE_O,                 // system clock gated
    output logic SUPPLY_GATE_O,                 // core supply gated
    output logic FLASH_ONESHOT_O,               // one-shot sets read time
    output logic [4:0] MODE_O                   // current mode one-hot
);
    // elaboration check: wake decode is built for five flags
    if (WAKE_W != pmc_pkg::WAKE_FLAG_W) begin : g_bad_wake_w
        $error("WAKE_W must be 5");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    pmc_pkg::pmc_mode_t mode_q, mode_d;
    logic bypass_q, bypass_d;
    logic pend_idle_q, pend_idle_d;
    logic pend_stop_q, pend_stop_d;
    logic [WAKE_W-1:0] flags_q, flags_d;
    logic [3:0] wake_en_q, wake_en_d;
    logic [7:0] rdata_q, rdata_d;
    logic any_rst;
    logic halt_d, crst_d, posc_d, aosc_d, cgate_d, sgate_d, oshot_d;
    logic wr_power_control_reg, wr_wake, wr_flash;

    // decode of a write to one address
    function automatic logic sfr_wr(input pmc_pkg::pmc_sfr_t s, input logic [7:0] a);
        sfr_wr = s.wr && (s.addr == a);
    endfunction : sfr_wr

    assign any_rst = WDT_RST_I | MCD_RST_I | EXT_RST_I;
    assign wr_power_control_reg = sfr_wr(SFR_I, pmc_pkg::POWER_CONTROL_ADDR);
    assign wr_wake = sfr_wr(SFR_I, pmc_pkg::WAKE_CONFIG_ADDR);
    assign wr_flash = sfr_wr(SFR_I, pmc_pkg::FLASH_READ_TIMING_ADDR);

    // ----------------------------------------
    // mode sequencing
    // ----------------------------------------
    always_comb begin
        mode_d = mode_q;
        pend_idle_d = pend_idle_q;
        pend_stop_d = pend_stop_q;
        // select bits latched until the instruction retires
        if (wr_power_control_reg) begin
            pend_idle_d = SFR_I.wdata[pmc_pkg::IDLE_SEL_POS];
            pend_stop_d = SFR_I.wdata[pmc_pkg::HALT_SEL_POS];
        end
        case (mode_q)
            pmc_pkg::PMC_NORMAL: begin
                if (wr_wake && SFR_I.wdata[pmc_pkg::SLEEP_SEL_POS]) begin
                    mode_d = pmc_pkg::PMC_SLEEP;
                end else if (wr_wake && SFR_I.wdata[pmc_pkg::SUSPEND_SEL_POS]) begin
                    mode_d = pmc_pkg::PMC_SUSPEND;
                end else if (INSN_DONE_I && pend_stop_q) begin
                    mode_d = pmc_pkg::PMC_STOP;
                end else if (INSN_DONE_I && pend_idle_q) begin
                    mode_d = pmc_pkg::PMC_IDLE;
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (IRQ_PEND_I) begin
                    mode_d = pmc_pkg::PMC_NORMAL;
                    pend_idle_d = 1'b0;
                end
            end
            pmc_pkg::PMC_STOP: begin
                mode_d = pmc_pkg::PMC_STOP;
            end
            pmc_pkg::PMC_SUSPEND: begin
                if ((WAKE_EV_I[3:0] & wake_en_q) != 4'h0 || WAKE_EV_I[4]) begin
                    mode_d = pmc_pkg::PMC_NORMAL;
                end
            end
            pmc_pkg::PMC_SLEEP: begin
                if ((WAKE_EV_I[2:0] & wake_en_q[2:0]) != 3'h0 || WAKE_EV_I[4]) begin
                    mode_d = pmc_pkg::PMC_NORMAL;
                end
            end
            default: mode_d = pmc_pkg::PMC_NORMAL;
        endcase
        // any reset leaves every mode, selects cleared
        if (any_rst) begin
            mode_d = pmc_pkg::PMC_NORMAL;
            pend_idle_d = 1'b0;
            pend_stop_d = 1'b0;
        end
    end

    // ----------------------------------------
    // registers: flash timing, wake config, read mux
    // ----------------------------------------
    always_comb begin
        bypass_d = bypass_q;
        wake_en_d = wake_en_q;
        flags_d = flags_q;
        rdata_d = rdata_q;
        if (wr_flash) begin
            bypass_d = SFR_I.wdata[pmc_pkg::ONESHOT_SKIP_POS];
        end
        if (wr_wake) begin
            wake_en_d = SFR_I.wdata[3:0] & pmc_pkg::WAKE_ENABLE_MASK[3:0];
        end
        // clear first, then set so a new event survives
        if (wr_wake && SFR_I.wdata[pmc_pkg::FLAG_CLEAR_POS]) begin
            flags_d = '0;
        end
        flags_d = flags_d | WAKE_EV_I;
        if (SFR_I.rd) begin
            case (SFR_I.addr)
                pmc_pkg::FLASH_READ_TIMING_ADDR:
                    rdata_d = {1'b0, bypass_q, 6'b00_0000};
                pmc_pkg::POWER_CONTROL_ADDR:
                    rdata_d = {6'b00_0000, pend_stop_q, pend_idle_q};
                pmc_pkg::WAKE_CONFIG_ADDR:
                    rdata_d = {3'b000, flags_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // registering; state held while CLK_EN_I is low
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            mode_q <= pmc_pkg::PMC_NORMAL;
            pend_idle_q <= 1'b0;
            pend_stop_q <= 1'b0;
            bypass_q <= pmc_pkg::FLASH_READ_TIMING_RST[pmc_pkg::ONESHOT_SKIP_POS];
            wake_en_q <= 4'h0;
            flags_q <= '0;
            rdata_q <= 8'h00;
        end else if (CLK_EN_I) begin
            mode_q <= mode_d;
            pend_idle_q <= pend_idle_d;
            pend_stop_q <= pend_stop_d;
            bypass_q <= bypass_d;
            wake_en_q <= wake_en_d;
            flags_q <= flags_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // outputs, registered
    // ----------------------------------------
    // next values of the mode, reset and one-shot outputs
    always_comb begin
        halt_d = (mode_d != pmc_pkg::PMC_NORMAL);
        crst_d = any_rst;
        posc_d = (mode_d == pmc_pkg::PMC_NORMAL)
            || (mode_d == pmc_pkg::PMC_IDLE);
        aosc_d = !((mode_d == pmc_pkg::PMC_SUSPEND)
            || (mode_d == pmc_pkg::PMC_SLEEP));
        cgate_d = (mode_d == pmc_pkg::PMC_SUSPEND);
        sgate_d = (mode_d == pmc_pkg::PMC_SLEEP);
        oshot_d = !bypass_d;
    end

    // output flops only register the next values
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            SFR_RDATA_O <= 8'h00;
            CPU_HALT_O <= 1'b0;
            CPU_RESET_O <= 1'b1;
            PREC_OSC_EN_O <= 1'b1;
            ALL_OSC_EN_O <= 1'b1;
            SYSCLK_GATE_O <= 1'b0;
            SUPPLY_GATE_O <= 1'b0;
            FLASH_ONESHOT_O <= 1'b1;
            MODE_O <= 5'b0_0001;
        end else if (CLK_EN_I) begin
            SFR_RDATA_O <= rdata_d;
            CPU_HALT_O <= halt_d;
            CPU_RESET_O <= crst_d;
            PREC_OSC_EN_O <= posc_d;
            ALL_OSC_EN_O <= aosc_d;
            SYSCLK_GATE_O <= cgate_d;
            SUPPLY_GATE_O <= sgate_d;
            FLASH_ONESHOT_O <= oshot_d;
            MODE_O <= mode_d;
        end
    end
endmodule : pmc_top

// ===== pmc_sva.sv
`timescale 1ns/1ps
module pmc_sva (
    input wire logic CLK_I, // clock
    input wire logic SYS_RST_I, // reset
    input wire logic CLK_EN_I, // enable
    input wire pmc_pkg::pmc_sfr_t SFR_I, // sfr access
    input wire logic INSN_DONE_I, // retired
    input wire logic IRQ_PEND_I, // irq
    input wire logic WDT_RST_I, // wdt
    input wire logic MCD_RST_I, // mcd
    input wire logic EXT_RST_I, // ext
    input wire logic CPU_HALT_O, // halt
    input wire logic CPU_RESET_O, // cpu reset
    input wire logic PREC_OSC_EN_O, // osc
    input wire logic SYSCLK_GATE_O, // gate
    input wire logic FLASH_ONESHOT_O, // oneshot
    input wire logic [4:0] MODE_O // mode
);
    // any reset source
    wire rst_any = WDT_RST_I | MCD_RST_I | EXT_RST_I;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    AST_RST_OUT: assert property (CLK_EN_I && rst_any |=> CPU_RESET_O)
        else $error("cpu reset missing");
    AST_RST_MODE: assert property (CLK_EN_I && rst_any |=> MODE_O == 5'h01)
        else $error("reset left low mode");
    AST_HALT: assert property (CPU_HALT_O == (MODE_O != 5'h01))
        else $error("halt disagrees with mode");
    AST_IDLE_IN: assert property ($rose(MODE_O == 5'h02) |-> $past(INSN_DONE_I))
        else $error("idle before retire");
    AST_STOP_HOLD: assert property (MODE_O == 5'h04 && !rst_any |=> MODE_O == 5'h04)
        else $error("stop left without reset");
    AST_STOP_OSC: assert property (MODE_O == 5'h04 |-> !PREC_OSC_EN_O)
        else $error("oscillator on in stop");
    AST_IDLE_WAKE: assert property (MODE_O == 5'h02 && IRQ_PEND_I && CLK_EN_I && !rst_any
        |=> MODE_O == 5'h01)
        else $error("irq did not end idle");
    AST_ONESHOT: assert property (CLK_EN_I && SFR_I.wr && SFR_I.addr == 8'hb7
        |=> FLASH_ONESHOT_O == !$past(SFR_I.wdata[6]))
        else $error("oneshot select wrong");
    AST_SUSP: assert property (MODE_O == 5'h08 |-> SYSCLK_GATE_O)
        else $error("clock not gated");
    AST_ONEHOT: assert property ($onehot(MODE_O))
        else $error("mode not one-hot");
    // main scenarios reached
    cover property (MODE_O == 5'h02);
    cover property (MODE_O == 5'h04);
    cover property (MODE_O == 5'h10);
endmodule : pmc_sva
bind pmc_top pmc_sva u_sva (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CLK_EN_I(CLK_EN_I),
    .SFR_I(SFR_I), .INSN_DONE_I(INSN_DONE_I), .IRQ_PEND_I(IRQ_PEND_I), .WDT_RST_I(WDT_RST_I),
    .MCD_RST_I(MCD_RST_I), .EXT_RST_I(EXT_RST_I), .CPU_HALT_O(CPU_HALT_O),
    .CPU_RESET_O(CPU_RESET_O), .PREC_OSC_EN_O(PREC_OSC_EN_O), .SYSCLK_GATE_O(SYSCLK_GATE_O),
    .FLASH_ONESHOT_O(FLASH_ONESHOT_O), .MODE_O(MODE_O));

// ===== pmc_cpu_model.sv
`timescale 1ns/1ps
module pmc_cpu_model (
    input wire logic clk_i, // clock
    output pmc_pkg::pmc_sfr_t sfr_o, // register access
    output logic done_o // write retired
);
    initial begin
        sfr_o = '0;
        done_o = 1'b0;
    end
    // write, retiring gap cycles later; reserved timing bits kept zero
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d, input int gap);
        @(posedge clk_i);
        sfr_o <= '{1'b1, 1'b0, a, (a == 8'hb7) ? (d & 8'h40) : d};
        @(posedge clk_i);
        sfr_o <= '0;
        repeat (gap) @(posedge clk_i);
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
        #1;
    endtask : sfr_wr
    // one-cycle read strobe
    task automatic sfr_rd(input logic [7:0] a);
        @(posedge clk_i);
        sfr_o <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_i);
        sfr_o <= '0;
        #1;
    endtask : sfr_rd
endmodule : pmc_cpu_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst = 1'b1, en = 1'b1, irq = 1'b0, wdt = 1'b0, missing_clock_detector = 1'b0, ext = 1'b0;
    logic [4:0] wake = 5'h00;
    logic [4:0] mode;
    logic [7:0] rdata;
    logic done, halt, crst, posc, aosc, cgate, sgate, oshot;
    pmc_pkg::pmc_sfr_t sfr;
    int fail_count = 0, comparisons = 0, cyc = 0;
    always #2.5 clk = ~clk;
    pmc_cpu_model CPU (.clk_i(clk), .sfr_o(sfr), .done_o(done));
    pmc_top DUT (.CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(en), .SFR_I(sfr), .INSN_DONE_I(done),
        .IRQ_PEND_I(irq), .WDT_RST_I(wdt), .MCD_RST_I(missing_clock_detector), .EXT_RST_I(ext), .WAKE_EV_I(wake),
        .SFR_RDATA_O(rdata), .CPU_HALT_O(halt), .CPU_RESET_O(crst), .PREC_OSC_EN_O(posc),
        .ALL_OSC_EN_O(aosc), .SYSCLK_GATE_O(cgate), .SUPPLY_GATE_O(sgate),
        .FLASH_ONESHOT_O(oshot), .MODE_O(mode));
    // compare and report
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic test_done;
        if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // bounded wait for a mode
    task automatic wmode(input logic [4:0] e);
        for (int i = 0; i < 4 && mode !== e; i++) @(posedge clk) #1;
        chk("mode", {3'h0, e}, {3'h0, mode});
    endtask : wmode
    // one-cycle reset source: 0 watchdog, 1 missing clock, 2 external
    task automatic pulse(input int w);
        @(posedge clk) begin
            wdt <= (w == 0);
            missing_clock_detector <= (w == 1);
            ext <= (w == 2);
        end
        @(posedge clk) {wdt, missing_clock_detector, ext} <= 3'b000;
        #1 chk("cpu_reset", 8'h01, {7'h00, crst});
        wmode(5'h01);
        @(posedge clk) #1 chk("cpu_reset_off", 8'h00, {7'h00, crst});
    endtask : pulse
    task automatic t_flash;
        CPU.sfr_wr(8'hb7, 8'hc0, 0);
        CPU.sfr_rd(8'hb7);
        chk("timing", 8'h40, rdata);
        chk("oneshot", 8'h00, {7'h00, oshot});
        CPU.sfr_wr(8'hb7, 8'h00, 0);
        chk("oneshot", 8'h01, {7'h00, oshot});
        CPU.sfr_rd(8'h00);
        chk("unmapped", 8'h00, rdata);
    endtask : t_flash
    task automatic t_idle;
        CPU.sfr_wr(8'h87, 8'h01, 3);
        wmode(5'h02);
        chk("halt_osc", 8'h07, {5'h00, aosc, halt, posc});
        @(posedge clk) begin en <= 1'b0; irq <= 1'b1; end
        repeat (3) @(posedge clk);
        #1 chk("frozen", 8'h02, {3'h0, mode});
        @(posedge clk) en <= 1'b1;
        wmode(5'h01);
        @(posedge clk) irq <= 1'b0;
        CPU.sfr_rd(8'h87);
        chk("idle_bit", 8'h00, rdata);
        CPU.sfr_wr(8'h87, 8'h01, 0);
        wmode(5'h02);
        pulse(0);
    endtask : t_idle
    task automatic t_stop(input int w);
        CPU.sfr_wr(8'h87, 8'h02, 1);
        wmode(5'h04);
        chk("prec_osc", 8'h00, {7'h00, posc});
        @(posedge clk) irq <= 1'b1;
        @(posedge clk) irq <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("stop_hold", 8'h04, {3'h0, mode});
        pulse(w);
    endtask : t_stop
    task automatic t_low(input logic [7:0] cfg, input logic [4:0] ev, input logic [4:0] m);
        CPU.sfr_wr(8'hb5, 8'h20, 0);
        CPU.sfr_rd(8'hb5);
        chk("flags_clr", 8'h00, {3'h0, rdata[4:0]});
        CPU.sfr_wr(8'hb5, cfg, 0);
        wmode(m);
        chk("gates", (m == 5'h08) ? 8'h02 : 8'h01, {5'h00, aosc, cgate, sgate});
        @(posedge clk) wake <= ev;
        @(posedge clk) wake <= 5'h00;
        wmode(5'h01);
        CPU.sfr_rd(8'hb5);
        chk("flags", {3'h0, ev}, {3'h0, rdata[4:0]});
    endtask : t_low
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1;
        chk("rst_mode", 8'h81, {oshot, halt, crst, mode});
        t_flash();
        t_idle();
        t_stop(1);
        t_stop(2);
        t_low(8'h41, 5'h01, 5'h08);
        t_low(8'h84, 5'h10, 5'h10);
        test_done();
    end
endmodule : tb
